// ===== src/cirt_top.sv
// configuration initialization: global init and output float sequencer
`timescale 1ns/1ps
module cirt_top
#(
  parameter int unsigned INIT_WIDTH_CYC = cirt_pkg::CIRT_INIT_WIDTH_CYC,
  parameter int unsigned FLOAT_EXTRA_CYC = cirt_pkg::CIRT_FLOAT_EXTRA_CYC,
  parameter int unsigned NUM_OUT = cirt_pkg::CIRT_NUM_OUT,
  parameter int unsigned NUM_REG = cirt_pkg::CIRT_NUM_REG,
  parameter logic [cirt_pkg::CIRT_NUM_REG-1:0] REG_INIT = cirt_pkg::CIRT_REG_INIT
) (
  input wire logic sys_clk,
  input wire logic reset,
  // pin: configuration in progress, high while loading
  input wire logic config_active,
  // pin: active-high external init request
  input wire logic external_init_buffer,
  // user data for the user registers
  input wire logic [NUM_REG-1:0] user_d,
  // user output values and enables in normal operation
  input wire logic [NUM_OUT-1:0] user_out,
  input wire logic [NUM_OUT-1:0] user_oe,
  // global init net, high while initializing
  output logic global_init_net,
  // global output float net, high while outputs float
  output logic global_output_float_net,
  // user register contents
  output logic [NUM_REG-1:0] user_q,
  // pad drive and pad enable
  output logic [NUM_OUT-1:0] pad_out,
  output logic [NUM_OUT-1:0] pad_oe
);
  import cirt_pkg::*;

  // synchronisers for pin inputs
  logic cfg_s1_reg; // first stage, read only by second
  logic cfg_s2_reg; // synchronised configuration level
  logic cfg_d_reg; // delayed copy for edge detect
  logic ext_s1_reg; // first stage, read only by second
  logic ext_s2_reg; // synchronised external init
  logic ext_d_reg; // delayed copy for edge detect
  logic por_reg; // power-up marker, first cycle after reset release
  logic por_done_reg; // power-up trigger already issued

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg_s1_reg <= 1'b0;
      cfg_s2_reg <= 1'b0;
      cfg_d_reg <= 1'b0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_d_reg <= 1'b0;
    end else begin
      cfg_s1_reg <= config_active;
      cfg_s2_reg <= cfg_s1_reg;
      cfg_d_reg <= cfg_s2_reg;
      ext_s1_reg <= external_init_buffer;
      ext_s2_reg <= ext_s1_reg;
      ext_d_reg <= ext_s2_reg;
    end
  end

  // power-up trigger, fired once after reset release
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      por_reg <= 1'b0;
      por_done_reg <= 1'b0;
    end else begin
      por_reg <= !por_done_reg;
      por_done_reg <= 1'b1;
    end
  end

  // configuration end is the falling edge of config_active
  wire logic cfg_end = cfg_d_reg && !cfg_s2_reg;
  // external init: active-high rising edge
  wire logic ext_rise = ext_s2_reg && !ext_d_reg;
  // init trigger: power-up, configuration end or user request
  wire logic init_trig = por_reg || cfg_end || ext_rise;
  // float trigger: power-up or configuration end
  wire logic float_trig = por_reg || cfg_end;

  logic init_pulse; // init generator output
  logic float_pulse; // float generator output

  // the init controller drives the global init net
  cirt_pulse_gen #(
    .WIDTH_CYC(INIT_WIDTH_CYC)
  ) u_init_gen (
    .sys_clk(sys_clk),
    .reset(reset),
    .trigger(init_trig),
    .pulse(init_pulse)
  );

  // separate generator for the float net, never shorter than init
  cirt_pulse_gen #(
    .WIDTH_CYC(INIT_WIDTH_CYC == 0 ? 0 : INIT_WIDTH_CYC + FLOAT_EXTRA_CYC)
  ) u_float_gen (
    .sys_clk(sys_clk),
    .reset(reset),
    .trigger(float_trig),
    .pulse(float_pulse)
  );

  // float held while configuring, through the edge-detect cycle after it and for its pulse;
  // the power-up window before the float pulse starts floats as well, so no pad leaks out
  wire logic float_next = float_pulse || cfg_s2_reg || cfg_d_reg
    || por_reg || !por_done_reg;
  // init follows the init generator pulse alone, never held for float
  wire logic init_next = init_pulse;

  logic init_reg; // global init net register
  logic float_reg; // global float net register
  // a running float is stretched while init is high, so float never ends first;
  // an init pulse on its own (external request) leaves the outputs driven
  wire logic float_hold = float_next || (init_next && float_reg);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      init_reg <= 1'b0;
      float_reg <= 1'b1;
    end else begin
      init_reg <= init_next;
      float_reg <= float_hold;
    end
  end
  assign global_init_net = init_reg;
  assign global_output_float_net = float_reg;

  // user registers: the common init net sets or clears asynchronously
  logic [NUM_REG-1:0] q_reg; // user register bank
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REG; gi++) begin : g_reg
      always_ff @(posedge sys_clk or posedge init_reg) begin
        if (init_reg) begin
          q_reg[gi] <= REG_INIT[gi];
        end else begin
          q_reg[gi] <= user_d[gi];
        end
      end
    end
  endgenerate
  assign user_q = q_reg;

  // pads: the float net clears every output enable; the pad value still follows user_out
  wire logic [NUM_OUT-1:0] oe_next = float_hold ? '0 : user_oe;
  logic [NUM_OUT-1:0] pad_out_reg; // registered pad value
  logic [NUM_OUT-1:0] pad_oe_reg; // registered pad enable
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pad_out_reg <= '0;
      pad_oe_reg <= '0;
    end else begin
      pad_out_reg <= user_out;
      pad_oe_reg <= oe_next;
    end
  end
  assign pad_out = pad_out_reg;
  assign pad_oe = pad_oe_reg;
endmodule // cirt_top

// ===== shared/cirt_pkg.sv
// package: constants for the configuration initialization sequencer
package cirt_pkg;
  // clock rate in hertz
  localparam int unsigned CIRT_CLK_HZ = 10_000_000;
  // default init pulse width in nanoseconds
  localparam int unsigned CIRT_INIT_WIDTH_NS = 1_000;
  // default init pulse width in clock cycles, rounded up
  localparam int unsigned CIRT_INIT_WIDTH_CYC =
    (CIRT_INIT_WIDTH_NS * (CIRT_CLK_HZ / 1_000_000) + 999) / 1000;
  // extra cycles the float pulse stays beyond the init pulse
  localparam int unsigned CIRT_FLOAT_EXTRA_CYC = 1;
  // counter width for pulse generators
  localparam int unsigned CIRT_CNT_W = 16;
  // number of general-purpose outputs
  localparam int unsigned CIRT_NUM_OUT = 8;
  // number of user registers
  localparam int unsigned CIRT_NUM_REG = 8;
  // default per-register initial values (set or cleared)
  localparam logic [CIRT_NUM_REG-1:0] CIRT_REG_INIT = 8'hA5;
  // pulse generator states
  typedef enum logic [1:0] {
    CIRT_IDLE = 2'b00,
    CIRT_PULSE = 2'b01,
    CIRT_DONE = 2'b10
  } cirt_state_t;
endpackage

// ===== src/cirt_pulse_gen.sv
// one-shot pulse generator started by a trigger, width in cycles
`timescale 1ns/1ps
module cirt_pulse_gen #(
  parameter int unsigned WIDTH_CYC = 10
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic trigger,
  output logic pulse
);
  import cirt_pkg::*;

  // the pulse lasts WIDTH_CYC cycles; zero width never pulses
  localparam logic [CIRT_CNT_W-1:0] WIDTH = CIRT_CNT_W'(WIDTH_CYC);
  localparam logic [CIRT_CNT_W-1:0] ONE = 16'h0001;

  cirt_state_t state_reg; // generator state
  cirt_state_t state_next; // next generator state
  logic [CIRT_CNT_W-1:0] cnt_reg; // cycles remaining
  logic [CIRT_CNT_W-1:0] cnt_next; // next count
  logic pulse_reg; // registered pulse
  wire logic zero_width = (WIDTH == '0); // generator disabled
  wire logic last = (cnt_reg == ONE); // final pulse cycle

  // next state and count
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      CIRT_IDLE: begin
        if (trigger && !zero_width) begin
          state_next = CIRT_PULSE;
          cnt_next = WIDTH;
        end
      end
      CIRT_PULSE: begin
        if (last) begin
          state_next = CIRT_DONE;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg - ONE;
        end
        if (trigger) begin // restart on a new trigger
          state_next = CIRT_PULSE;
          cnt_next = WIDTH;
        end
      end
      CIRT_DONE: begin
        if (trigger && !zero_width) begin
          state_next = CIRT_PULSE;
          cnt_next = WIDTH;
        end
      end
      default: begin
        state_next = CIRT_IDLE;
        cnt_next = '0;
      end
    endcase
  end

  // the pulse is high while counting
  wire logic pulse_next = (state_next == CIRT_PULSE);

  // state registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= CIRT_IDLE;
      cnt_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulse = pulse_reg;
endmodule // cirt_pulse_gen

// ===== tb/cirt_properties.sv
// checker for the configuration initialization sequencer
`timescale 1ns/1ps
module cirt_properties #(
  parameter int unsigned INIT_WIDTH_CYC = 10,
  parameter logic [7:0] REG_INIT = 8'hA5
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic config_active,
  input wire logic external_init_buffer,
  input wire logic global_init_net,
  input wire logic global_output_float_net,
  input wire logic [7:0] user_q,
  input wire logic [7:0] pad_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // length of the current init pulse in cycles
  int unsigned hi_cnt;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) hi_cnt <= 0;
    else hi_cnt <= global_init_net ? hi_cnt + 1 : 0;
  end
  power_up_pulse_a: assert property (INIT_WIDTH_CYC != 0 && $fell(reset)
    |-> ##[1:5] global_init_net)
    else $error("no init pulse after reset");
  zero_width_a: assert property (INIT_WIDTH_CYC == 0 |-> !global_init_net)
    else $error("init pulse with zero width");
  init_width_a: assert property ($fell(global_init_net) |-> hi_cnt >= INIT_WIDTH_CYC)
    else $error("init pulse too short");
  init_value_a: assert property (global_init_net |-> user_q == REG_INIT)
    else $error("registers not at initial value");
  release_float_a: assert property ($fell(reset) |-> global_output_float_net [*3])
    else $error("outputs not floating at release");
  config_float_a: assert property (config_active [*4] |-> global_output_float_net)
    else $error("outputs driven during configuration");
  pads_off_a: assert property (global_output_float_net && $past(global_output_float_net)
    |-> pad_oe == 8'h00)
    else $error("pad enabled while floating");
  float_order_a: assert property ($fell(global_output_float_net) |-> !global_init_net)
    else $error("float ended before init");
  ext_init_a: assert property (INIT_WIDTH_CYC != 0 && $rose(external_init_buffer)
    |-> ##[2:7] global_init_net)
    else $error("external request ignored");
  float_apart_a: assert property ($rose(global_init_net) && !global_output_float_net
    && !config_active && !$past(config_active) |=> !global_output_float_net)
    else $error("external init floated outputs");
  cover property ($fell(global_init_net));
  cover property (config_active [*4]);
  cover property ($rose(external_init_buffer));
endmodule // cirt_properties

bind cirt_top cirt_properties #(.INIT_WIDTH_CYC(INIT_WIDTH_CYC), .REG_INIT(REG_INIT)) chk (
  .sys_clk(sys_clk), .reset(reset), .config_active(config_active),
  .external_init_buffer(external_init_buffer), .global_init_net(global_init_net),
  .global_output_float_net(global_output_float_net), .user_q(user_q), .pad_oe(pad_oe));

// ===== tb/cirt_partner.sv
// partner: external init driver and pad wire resolution
`timescale 1ns/1ps
module cirt_partner (
  input wire logic sys_clk,
  input wire logic fire,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  output logic external_init_buffer,
  output logic [7:0] pad_lvl
);
  // one active-high init pulse per request, launched on the clock
  always @(posedge sys_clk) external_init_buffer <= fire;
  // pads carry a pull-up, so a floating pad reads high
  assign pad_lvl = (pad_out & pad_oe) | ~pad_oe;
endmodule // cirt_partner

// ===== tb/tb_top.sv
// testbench for the configuration initialization sequencer
`timescale 1ns/1ps
module tb_top;
  import cirt_pkg::*;
  localparam int W = 3; // shortened init width
  logic sys_clk = 1'b0, reset = 1'b1, config_active = 1'b0, fire = 1'b0;
  logic [7:0] user_d = '0, user_out = '0, user_oe = '0;
  logic init_w, float_w, ext_w;
  logic init0_w, zero_seen = 1'b0; // zero-width variant init net and its sticky flag
  logic [7:0] user_q, pad_out, pad_oe, pad_lvl;
  int num_errors = 0, checked = 0, n;
  always #50 sys_clk = ~sys_clk;
  cirt_partner pm (.sys_clk(sys_clk), .fire(fire), .pad_out(pad_out), .pad_oe(pad_oe),
    .external_init_buffer(ext_w), .pad_lvl(pad_lvl));
  cirt_top #(.INIT_WIDTH_CYC(W)) dut (.sys_clk(sys_clk), .reset(reset),
    .config_active(config_active), .external_init_buffer(ext_w), .user_d(user_d),
    .user_out(user_out), .user_oe(user_oe), .global_init_net(init_w),
    .global_output_float_net(float_w), .user_q(user_q), .pad_out(pad_out), .pad_oe(pad_oe));
  // zero-width variant: its init net must never rise
  cirt_top #(.INIT_WIDTH_CYC(0)) dut_zero (.sys_clk(sys_clk), .reset(reset),
    .config_active(config_active), .external_init_buffer(ext_w), .user_d(user_d),
    .user_out(user_out), .user_oe(user_oe), .global_init_net(init0_w),
    .global_output_float_net(), .user_q(), .pad_out(), .pad_oe());
  // remember any init activity of the zero-width variant
  always @(posedge sys_clk)
    if (init0_w !== 1'b0) zero_seen <= 1'b1;
  // compare one seen value with its expectation
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // wait for the init pulse, then measure it while checking outputs
  task automatic measure(input logic flt);
    n = 0;
    for (int i = 0; i < 20 && init_w !== 1'b1; i++) @(negedge sys_clk);
    while (init_w === 1'b1 && n < 20) begin
      cmp(user_q, CIRT_REG_INIT);
      cmp({7'b0, float_w}, {7'b0, flt});
      n++;
      @(negedge sys_clk);
    end
    cmp(8'(n), 8'(W));
  endtask
  // verdict and end of run
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #50us;
    num_errors++;
    complete_run();
  end
  // main sequence
  initial begin
    void'($urandom(44));
    repeat (8) @(negedge sys_clk);
    reset = 0;
    measure(1'b1);
    cmp({7'b0, float_w}, 8'h01);
    @(negedge sys_clk);
    $display("power-up test done");
    // normal operation: registers and pads follow the user
    repeat (3) begin
      user_d = 8'($urandom);
      user_out = 8'($urandom);
      user_oe = 8'($urandom);
      @(negedge sys_clk);
      cmp(user_q, user_d);
      cmp(pad_oe, user_oe);
      cmp(pad_lvl, (user_out & user_oe) | ~user_oe);
    end
    $display("normal test done");
    config_active = 1;
    repeat (6) @(negedge sys_clk);
    cmp({7'b0, float_w}, 8'h01);
    cmp(pad_lvl, 8'hFF);
    config_active = 0;
    measure(1'b1);
    repeat (2) @(negedge sys_clk);
    $display("configuration test done");
    fire = 1;
    @(negedge sys_clk);
    fire = 0;
    measure(1'b0);
    $display("external init test done");
    reset = 1;
    repeat (2) @(negedge sys_clk);
    cmp({6'b0, init_w, float_w}, 8'h01);
    reset = 0;
    measure(1'b1);
    $display("second reset test done");
    cmp({7'b0, zero_seen}, 8'h00);
    $display("zero width test done");
    complete_run();
  end
endmodule // tb_top
